// ### rtl/dcsp_host.sv
// Controller end of the serial register port: makes clock and frames.
`timescale 1ns/1ps
`default_nettype none
module dcsp_host
    import dcsp_pkg::*;
#(
    parameter int HALF = DCSP_SCLK_HALF_CYC // Serial clock half period.
) (
    input wire logic clk, // System clock, 200 MHz.
    input wire logic srst, // Synchronous reset, active high.
    dcsp_if.controller link, // Serial link pins.
    input wire logic start, // One-cycle request while idle.
    input wire logic start_rd, // Request is a read.
    input wire logic [DCSP_ADDR_BITS-1:0] start_addr, // Start address.
    input wire logic [7:0] start_words, // Data words, 0 means 256.
    input wire logic use_three_line, // Device is in three-line mode.
    input wire logic [DCSP_WORD_BITS-1:0] wr_data, // Next write word.
    output logic wr_take, // Pulse: wr_data was taken.
    output logic [DCSP_WORD_BITS-1:0] rd_data, // Last read word.
    output logic rd_valid, // Pulse: rd_data is new.
    output logic busy // Frame in progress.
);

    typedef struct packed {
        dcsp_host_state_e st;
        logic [DCSP_DIV_BITS-1:0] div;
        logic sclk;
        logic cs_n;
        logic o;
        logic oe_n;
        logic [DCSP_WORD_BITS-1:0] sh;
        logic [DCSP_WORD_BITS-1:0] rx;
        logic [DCSP_CNT_BITS-1:0] nbit;
        logic [7:0] words;
        logic cmd;
        logic rd;
        logic tl;
        logic sdio_m;
        logic sdio_s;
        logic sdo_m;
        logic sdo_s;
        logic [DCSP_WORD_BITS-1:0] rd_data;
        logic rd_valid;
        logic wr_take;
        logic busy;
    } dcsp_host_s;

    dcsp_host_s r;
    dcsp_host_s next_r;
    logic tick;
    logic rx_bit;

    // Each return line is synchronised on its own; the mode picks
    // between the settled copies only.
    // Read line by mode.
    assign rx_bit = r.tl ? r.sdio_s : r.sdo_s;
    assign tick = (r.div == DCSP_DIV_BITS'(HALF - 1));
    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.sdio_ctl_o = r.o;
    assign link.sdio_ctl_oe_n = r.oe_n;
    assign wr_take = r.wr_take;
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign busy = r.busy;

    // Next state of the controller end.
    always_comb begin
        next_r = r;
        next_r.sdio_m = link.sdio;
        next_r.sdio_s = r.sdio_m;
        next_r.sdo_m = link.serial_data_out_line;
        next_r.sdo_s = r.sdo_m;
        next_r.rd_valid = 1'b0;
        next_r.wr_take = 1'b0;
        next_r.div = tick ? '0 : r.div + 8'h01;

        unique case (r.st)
            HOST_IDLE: begin
                next_r.div = '0;
                // A multiword register burst should start at the top
                // address; the user owns that choice.
                // Burst start address.
                if (start) begin
                    next_r.st = HOST_SHIFT;
                    next_r.cs_n = 1'b0;
                    next_r.oe_n = 1'b0;
                    next_r.o = start_rd;
                    next_r.sh = {start_rd, start_addr};
                    next_r.nbit = DCSP_FIRST_BIT;
                    next_r.words = start_words;
                    next_r.cmd = 1'b1;
                    next_r.rd = start_rd;
                    next_r.tl = use_three_line;
                    next_r.busy = 1'b1;
                end
            end

            HOST_SHIFT: begin
                if (tick) begin
                    next_r.sclk = ~r.sclk;
                end
                if (tick && !r.sclk) begin
                    next_r.rx = {r.rx[DCSP_WORD_BITS-2:0], rx_bit};
                    next_r.nbit = r.nbit + 4'h1;
                    if (r.nbit == DCSP_LAST_BIT) begin
                        next_r.cmd = 1'b0;
                        if (!r.cmd) begin
                            next_r.words = r.words - 8'h01;
                            if (r.rd) begin
                                next_r.rd_data = {r.rx[DCSP_WORD_BITS-2:0],
                                    rx_bit};
                                next_r.rd_valid = 1'b1;
                            end
                            if (r.words == 8'h01) begin
                                next_r.st = HOST_END;
                                next_r.nbit = DCSP_FIRST_BIT;
                            end
                        end
                    end
                end
                // Bits change on falling edges; a read frees the line.
                if (tick && r.sclk) begin
                    if (r.nbit == DCSP_FIRST_BIT) begin
                        if (r.rd) begin
                            next_r.oe_n = 1'b1;
                        end else begin
                            next_r.sh = wr_data;
                            next_r.o = wr_data[DCSP_WORD_BITS-1];
                            next_r.wr_take = 1'b1;
                        end
                    end else begin
                        next_r.sh = {r.sh[DCSP_WORD_BITS-2:0], 1'b0};
                        next_r.o = r.sh[DCSP_WORD_BITS-2];
                    end
                end
            end

            HOST_END: begin
                // Clock low, then select high, then idle: one half each.
                // Select ends frame.
                if (tick) begin
                    next_r.nbit = r.nbit + 4'h1;
                    if (r.nbit == 4'h0) begin
                        next_r.sclk = 1'b0;
                        next_r.oe_n = 1'b1;
                    end
                    if (r.nbit == 4'h1) begin
                        next_r.cs_n = 1'b1;
                    end
                    if (r.nbit == 4'h2) begin
                        next_r.st = HOST_IDLE;
                        next_r.busy = 1'b0;
                    end
                end
            end

            default: begin
                next_r.st = HOST_IDLE;
            end
        endcase
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '{st: HOST_IDLE, cs_n: 1'b1, oe_n: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

endmodule // dcsp_host
`default_nettype wire

// ### rtl/dcsp_pkg.sv
// Shared constants, state types and helpers for the serial register port.
package dcsp_pkg;

    // Link word layout: one direction flag and a 15-bit address, MSB first.
    localparam int DCSP_WORD_BITS = 16;
    localparam int DCSP_ADDR_BITS = 15;
    localparam int DCSP_CNT_BITS = 4;
    localparam logic [3:0] DCSP_LAST_BIT = 4'hF;
    localparam logic [3:0] DCSP_FIRST_BIT = 4'h0;
    localparam int DCSP_RW_POS = 15;

    // Register space reached by the serial port.
    localparam logic [14:0] DCSP_SETUP_ADDR = 15'h0000;
    localparam logic [14:0] DCSP_ARM_ADDR = 15'h001D;
    localparam logic [14:0] DCSP_BURST_TOP = 15'h0060;
    localparam int DCSP_3W_POS = 14;
    localparam int DCSP_3W_MIRROR_POS = 1;
    localparam int DCSP_ARM_POS = 0;
    localparam int DCSP_REG_COUNT = int'(DCSP_BURST_TOP) + 1;
    localparam int DCSP_IDX_BITS = 7;
    localparam logic [15:0] DCSP_REG_RESET = 16'h0000;

    // Controller serial clock: half period as a time, then in cycles.
    localparam int DCSP_CLK_PS = 5000;
    localparam int DCSP_SCLK_HALF_NS = 40;
    localparam int DCSP_SCLK_HALF_CYC =
        (DCSP_SCLK_HALF_NS * 1000 + DCSP_CLK_PS - 1) / DCSP_CLK_PS;
    localparam int DCSP_DIV_BITS = 8;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_CMD = 3'b010,
        DEV_DATA = 3'b100
    } dcsp_dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b001,
        HOST_SHIFT = 3'b010,
        HOST_END = 3'b100
    } dcsp_host_state_e;

    // Whole state of the device end.
    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_q;
        logic cs_m;
        logic cs_s;
        logic din_m;
        logic din_s;
        dcsp_dev_state_e st;
        logic [DCSP_CNT_BITS-1:0] nbit;
        logic [DCSP_WORD_BITS-1:0] sh;
        logic rd;
        logic [DCSP_ADDR_BITS-1:0] addr;
        logic load;
        logic [DCSP_WORD_BITS-1:0] tx;
        logic sdio_o;
        logic sdio_oe_n;
        logic serial_data_out_line;
        logic wr_en;
        logic [DCSP_ADDR_BITS-1:0] wr_addr;
        logic [DCSP_WORD_BITS-1:0] wr_data;
        logic three_line;
    } dcsp_dev_s;

    localparam dcsp_dev_s DCSP_DEV_RESET = '{st: DEV_IDLE, cs_m: 1'b1,
        cs_s: 1'b1, sdio_oe_n: 1'b1, default: '0};

    // Next burst address: steps down inside the register space only, holding at the setup address.
    function automatic logic [14:0] dcsp_next_addr(input logic [14:0] a);
        if (a <= DCSP_BURST_TOP && a != DCSP_SETUP_ADDR) begin
            return a - 15'h0001;
        end
        return a;
    endfunction

endpackage

// ### rtl/dcsp_if.sv
// Pins between the serial controller and the device's register port.
`timescale 1ns/1ps
`default_nettype none
interface dcsp_if;
    logic sclk; // Serial clock, made by the controller.
    logic cs_n; // Frame select, active low.
    logic sdio_ctl_o; // Controller drive value on the shared line.
    logic sdio_ctl_oe_n; // Controller drives the shared line when low.
    logic sdio_dev_o; // Device drive value on the shared line.
    logic sdio_dev_oe_n; // Device drives the shared line when low.
    logic serial_data_out_line; // Device serial output line, four-line mode.
    logic sdio; // Resolved level of the shared line.

    // The shared line is pulled high when neither end drives it.
    assign sdio = !sdio_dev_oe_n ? sdio_dev_o :
        (!sdio_ctl_oe_n ? sdio_ctl_o : 1'b1);

    modport device (input sclk, input cs_n, input sdio,
        output sdio_dev_o, output sdio_dev_oe_n, output serial_data_out_line);
    modport controller (output sclk, output cs_n, output sdio_ctl_o,
        output sdio_ctl_oe_n, input sdio, input serial_data_out_line);
endinterface
`default_nettype wire

// ### rtl/dcsp_regfile.sv
// Shadow and active register arrays behind the serial port.
`timescale 1ns/1ps
`default_nettype none
module dcsp_regfile
    import dcsp_pkg::*;
#(
    parameter int REGS = DCSP_REG_COUNT // Registers in the space.
) (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic wr_en, // One-cycle write strobe.
    input wire logic [DCSP_ADDR_BITS-1:0] wr_addr, // Write address.
    input wire logic [DCSP_WORD_BITS-1:0] wr_data, // Write data.
    input wire logic [DCSP_ADDR_BITS-1:0] rd_addr, // Read address.
    output logic [DCSP_WORD_BITS-1:0] rd_data, // Shadow word, no latency.
    output logic three_line, // Three-line mode from the setup word.
    input wire logic [DCSP_IDX_BITS-1:0] user_idx, // Active word index.
    output logic [DCSP_WORD_BITS-1:0] user_word // Active word, registered.
);

    typedef struct packed {
        logic [REGS-1:0][DCSP_WORD_BITS-1:0] shadow;
        logic [REGS-1:0][DCSP_WORD_BITS-1:0] active;
        logic arm;
        logic [DCSP_WORD_BITS-1:0] user_word;
    } dcsp_rf_s;

    dcsp_rf_s r;
    dcsp_rf_s next_r;

    // Reads always see the shadow copy, never the active one.
    // Reads return shadow.
    assign rd_data = (rd_addr < DCSP_ADDR_BITS'(REGS)) ?
        r.shadow[rd_addr[DCSP_IDX_BITS-1:0]] : DCSP_REG_RESET;
    assign three_line = r.shadow[DCSP_SETUP_ADDR][DCSP_3W_POS] |
        r.shadow[DCSP_SETUP_ADDR][DCSP_3W_MIRROR_POS];
    assign user_word = r.user_word;

    // Transfer on arm, self-clear the arm bit, then apply a new write.
    always_comb begin
        next_r = r;
        next_r.arm = 1'b0;
        if (r.arm) begin
            next_r.active = r.shadow;
            next_r.shadow[DCSP_ARM_ADDR][DCSP_ARM_POS] = 1'b0;
        end
        // A write in the clearing cycle wins, so a fresh arm is not lost.
        if (wr_en && wr_addr < DCSP_ADDR_BITS'(REGS)) begin
            next_r.shadow[wr_addr[DCSP_IDX_BITS-1:0]] = wr_data;
            if (wr_addr == DCSP_ARM_ADDR && wr_data[DCSP_ARM_POS]) begin
                next_r.arm = 1'b1;
            end
        end
        next_r.user_word = (user_idx < DCSP_IDX_BITS'(REGS)) ?
            r.active[user_idx] : DCSP_REG_RESET;
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // dcsp_regfile
`default_nettype wire

// ### rtl/dcsp_device.sv
// Device end of the serial register port: framing, shifting and readback.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Low select frames; bits taken on rising clock.
// - First bit high reads, low writes.
// - Command word MSB first: flag, 15-bit address.
// - Burst words step the address down.
// - Controller starts bursts at any start_addr, not only at 0x60.
// - Writes keep the shared line an input.
// - Reads drive the shared line in three-line mode.
// - Setup bits 14 and 1 pick line mode.
// - Four-line reads leave on the output line.
// - Select high ends frame, resets bit position.
// - Reads return the shadow copy.
// - Writing update bit 0 arms shadow transfer.
module dcsp_device
    import dcsp_pkg::*;
(
    input wire logic clk, // System clock, 200 MHz.
    input wire logic srst, // Synchronous reset, active high.
    dcsp_if.device link, // Serial link pins.
    input wire logic [DCSP_IDX_BITS-1:0] user_idx, // Active word index.
    output logic [DCSP_WORD_BITS-1:0] user_word, // Active word value.
    output logic three_line // Three-line mode in force.
);

    // Whole state as one record, plus strobes.
    dcsp_dev_s r;
    dcsp_dev_s next_r;
    logic sclk_rise;
    logic sclk_fall;
    logic word_done;
    logic [DCSP_WORD_BITS-1:0] word_in;
    logic [DCSP_WORD_BITS-1:0] rf_rdata;
    logic rf_three_line;

    // Shadow and active storage; reads look up the current address.
    // The lookup is combinational; the word is
    // caught a cycle later, away from the pins.
    dcsp_regfile #(
        .REGS(DCSP_REG_COUNT)
    ) u_regs (
        .clk(clk),
        .srst(srst),
        .wr_en(r.wr_en),
        .wr_addr(r.wr_addr),
        .wr_data(r.wr_data),
        .rd_addr(r.addr),
        .rd_data(rf_rdata),
        .three_line(rf_three_line),
        .user_idx(user_idx),
        .user_word(user_word)
    );

    // Edges are found on the synchronised serial clock only; the first
    // stage of each synchroniser feeds nothing but the second.
    // All three pins pass the same two stages,
    // so a bit set up on a falling edge is still
    // steady when its rising edge shows up here.
    // Limitation: a serial half period must span
    // at least six system clocks for reads.
    // Rising edge capture.
    assign sclk_rise = r.sclk_s & ~r.sclk_q;
    // Both edges come from the same two stages.
    // Falling edge launch.
    assign sclk_fall = ~r.sclk_s & r.sclk_q;
    // Bits enter at the bottom and climb to the top.
    // MSB first assembly.
    assign word_in = {r.sh[DCSP_WORD_BITS-2:0], r.din_s};
    assign word_done = sclk_rise && (r.nbit == DCSP_LAST_BIT);

    // Pin outputs come straight from the state register.
    // No logic sits between state and a pin.
    assign link.sdio_dev_o = r.sdio_o;
    assign link.sdio_dev_oe_n = r.sdio_oe_n;
    assign link.serial_data_out_line = r.serial_data_out_line;
    assign three_line = r.three_line;

    // Next state of the whole device end.
    // Every field starts from its held value.
    always_comb begin
        next_r = r;

        // Two flip-flops on every pin before any logic looks at it.
        next_r.sclk_m = link.sclk;
        next_r.sclk_s = r.sclk_m;
        next_r.sclk_q = r.sclk_s;
        next_r.cs_m = link.cs_n;
        next_r.cs_s = r.cs_m;
        next_r.din_m = link.sdio;
        next_r.din_s = r.din_m;

        // Strobes last one cycle.
        // The write strobe carries its own address
        // and data, so the burst address may move on.
        next_r.wr_en = 1'b0;
        next_r.load = 1'b0;

        // The line mode follows the setup word as soon as it is written.
        // A change takes effect at the next falling edge.
        // Mode from setup word.
        next_r.three_line = rf_three_line;

        // A pending read word is fetched one cycle after its address is
        // settled, well before the falling edge that sends its MSB.
        // Shadow word loaded.
        if (r.load) begin
            next_r.tx = rf_rdata;
        end

        unique case (r.st)
            DEV_IDLE: begin
                // A frame always opens on a command word.
                // Select opens frame.
                if (!r.cs_s) begin
                    next_r.st = DEV_CMD;
                    next_r.nbit = DCSP_FIRST_BIT;
                end
            end

            DEV_CMD: begin
                // Flag and address are taken together
                // once the sixteenth bit is in.
                if (sclk_rise) begin
                    next_r.sh = word_in;
                    next_r.nbit = r.nbit + 4'h1;
                end
                if (word_done) begin
                    next_r.rd = word_in[DCSP_RW_POS];
                    next_r.addr = word_in[DCSP_ADDR_BITS-1:0];
                    next_r.load = word_in[DCSP_RW_POS];
                    next_r.st = DEV_DATA;
                end
            end

            DEV_DATA: begin
                if (sclk_rise) begin
                    next_r.sh = word_in;
                    next_r.nbit = r.nbit + 4'h1;
                end
                if (word_done) begin
                    // Reads write nothing; the address still steps.
                    // Write lands in shadow.
                    if (!r.rd) begin
                        next_r.wr_en = 1'b1;
                        next_r.wr_addr = r.addr;
                        next_r.wr_data = word_in;
                    end
                    // Above the register space the address holds still;
                    // a burst that does not start at the top of the space
                    // therefore walks only part of it.
                    // Burst address decrement.
                    next_r.addr = dcsp_next_addr(r.addr);
                    next_r.load = r.rd;
                end
                // The word is refilled at each boundary,
                // well before the next falling edge.
                // Writes never turn the shared line round.
                // Write keeps input.
                if (sclk_fall && r.rd) begin
                    if (r.three_line) begin
                        next_r.sdio_o = r.tx[DCSP_WORD_BITS-1];
                        next_r.sdio_oe_n = 1'b0;
                    end else begin
                        next_r.serial_data_out_line = r.tx[DCSP_WORD_BITS-1];
                    end
                    next_r.tx = {r.tx[DCSP_WORD_BITS-2:0], 1'b0};
                end
            end

            default: begin
                // An illegal code falls back to waiting for a frame.
                next_r.st = DEV_IDLE;
            end
        endcase

        // Raising select ends the frame from any state and releases the
        // shared line; partial words are dropped unwritten.
        // It sits after the case so that it wins over
        // any shift or launch of the same cycle.
        // Frame end resets.
        if (r.cs_s) begin
            next_r.st = DEV_IDLE;
            next_r.nbit = DCSP_FIRST_BIT;
            next_r.sdio_oe_n = 1'b1;
            next_r.serial_data_out_line = 1'b0;
        end
    end

    // Register the whole state.
    // Reset holds select high in the synchroniser,
    // so no false frame opens after release.
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= DCSP_DEV_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule // dcsp_device
`default_nettype wire

// ### verification/dcsp_link_sva.sv
// Checker for the serial link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module dcsp_link_sva (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic sclk, // Serial clock.
    input wire logic cs_n, // Frame select, active low.
    input wire logic sdio_ctl_o, // Host drive value.
    input wire logic sdio_ctl_oe_n, // Host drives when low.
    input wire logic sdio_dev_o, // Device drive value.
    input wire logic sdio_dev_oe_n, // Device drives when low.
    input wire logic serial_data_out_line, // Device output line.
    input wire logic sdio // Resolved shared line.
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic sclk_q;
    logic cs_q;
    logic wr_fr;
    logic [3:0] age;
    logic [11:0] nrise;

    // Edge history of the link; age counts cycles since a clock fall.
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            wr_fr <= 1'b0;
            age <= 4'hF;
            nrise <= 12'h000;
        end else begin
            sclk_q <= sclk;
            cs_q <= cs_n;
            wr_fr <= cs_n ? 1'b0 : (cs_q ? !sdio_ctl_o : wr_fr);
            age <= (sclk_q && !sclk) ? 4'h0 :
                (age == 4'hF ? age : age + 4'h1);
            nrise <= cs_n ? 12'h000 : nrise + {11'h000, sclk && !sclk_q};
        end
    end

    // Link relations; the window on age is tight so a launch on the
    // rising edge, eight cycles after the fall, cannot slip through.
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    ctl_stable_a: assert property ($rose(sclk) && !sdio_ctl_oe_n |->
        $stable(sdio_ctl_o))
        else $error("host data changes at a rising clock");
    cmd_owner_a: assert property (!cs_n && nrise < 12'h010 |->
        !sdio_ctl_oe_n && sdio_dev_oe_n && sdio == sdio_ctl_o)
        else $error("command word not driven by the host alone");
    one_driver_a: assert property (!(!sdio_dev_oe_n && !sdio_ctl_oe_n))
        else $error("both ends drive the shared line");
    write_input_a: assert property (wr_fr |-> sdio_dev_oe_n)
        else $error("device drives the line in a write frame");
    launch_fall_a: assert property (!cs_n && ($changed(serial_data_out_line) ||
        (!sdio_dev_oe_n && $changed(sdio_dev_o))) |-> age <= 4'h6)
        else $error("read bit not launched after a falling edge");
    release_a: assert property ($rose(cs_n) |-> ##[0:6] sdio_dev_oe_n)
        else $error("device holds the line after the frame");
    whole_words_a: assert property ($rose(cs_n) |->
        nrise[3:0] == 4'h0 && nrise != 12'h000)
        else $error("frame is not a whole number of words");

    wr_frame_c: cover property ($rose(cs_n) && wr_fr);
    rd_3line_c: cover property ($fell(sdio_dev_oe_n));
    sdo_bit_c: cover property (!cs_n && $changed(serial_data_out_line));
endmodule // dcsp_link_sva
`default_nettype wire

// ### verification/dac_config_serial_port_bench.sv
// Bench joining the host and device ends over one link.
`timescale 1ns/1ps
`default_nettype none
module dac_config_serial_port_bench import dcsp_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic start_rd = 1'b0;
    logic [14:0] start_addr = 15'h0000;
    logic [7:0] start_words = 8'h01;
    logic use_3 = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic [6:0] user_idx = 7'h00;
    logic wr_take;
    logic rd_valid;
    logic busy;
    logic three_line;
    logic [15:0] rd_data;
    logic [15:0] user_word;
    logic [15:0] wq [4];
    logic [15:0] rq [4];
    int miscompares = 0;
    int comparisons = 0;

    dcsp_if i_dcsp_if ();
    dcsp_host i_dcsp_host (.clk(clk), .srst(srst), .link(i_dcsp_if),
        .start(start), .start_rd(start_rd), .start_addr(start_addr),
        .start_words(start_words), .use_three_line(use_3),
        .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy));
    dcsp_device i_dcsp_device (.clk(clk), .srst(srst), .link(i_dcsp_if),
        .user_idx(user_idx), .user_word(user_word),
        .three_line(three_line));
    dcsp_link_sva i_dcsp_link_sva (.clk(clk), .srst(srst),
        .sclk(i_dcsp_if.sclk), .cs_n(i_dcsp_if.cs_n),
        .sdio_ctl_o(i_dcsp_if.sdio_ctl_o),
        .sdio_ctl_oe_n(i_dcsp_if.sdio_ctl_oe_n),
        .sdio_dev_o(i_dcsp_if.sdio_dev_o),
        .sdio_dev_oe_n(i_dcsp_if.sdio_dev_oe_n),
        .serial_data_out_line(i_dcsp_if.serial_data_out_line), .sdio(i_dcsp_if.sdio));

    // System clock, 5 ns period.
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up();
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One frame of n words; write words come from wq, reads go to rq.
    task automatic xfer(input logic rd, input logic [14:0] a,
        input int n, input logic three);
        int wi;
        int ri;
        int k;
        wi = 0;
        ri = 0;
        @(posedge clk);
        start <= 1'b1;
        start_rd <= rd;
        start_addr <= a;
        start_words <= 8'(n);
        use_3 <= three;
        wr_data <= wq[0];
        @(posedge clk);
        start <= 1'b0;
        // The host wants the next word as soon as it takes one.
        for (k = 0; k < 20000; k++) begin
            @(posedge clk);
            if (wr_take === 1'b1 && wi < 3) begin
                wi++;
                wr_data <= wq[wi];
            end
            if (rd_valid === 1'b1 && ri < 4) begin
                rq[ri] = rd_data;
                ri++;
            end
            if (busy === 1'b0) begin
                break;
            end
        end
        if (k == 20000) begin
            miscompares++;
            wrap_up();
        end
        chk("words", 16'(rd ? ri : wi), 16'(n));
    endtask

    // Active word lookup; one cycle of latency plus margin.
    task automatic peek(input logic [6:0] idx, output logic [15:0] v);
        user_idx <= idx;
        repeat (3) @(posedge clk);
        v = user_word;
    endtask

    // Burst from the top address, read back over the output line.
    task automatic t_burst();
        logic [15:0] v;
        wq = '{16'h1234, 16'hABCD, 16'h5A0F, 16'h0000};
        xfer(1'b0, DCSP_BURST_TOP, 3, 1'b0);
        xfer(1'b1, DCSP_BURST_TOP, 3, 1'b0);
        chk("burst0", rq[0], 16'h1234);
        chk("burst1", rq[1], 16'hABCD);
        chk("burst2", rq[2], 16'h5A0F);
        xfer(1'b1, 15'h005E, 1, 1'b0);
        chk("word5e", rq[0], 16'h5A0F);
        peek(7'h60, v);
        chk("unarmed", v, 16'h0000);
    endtask

    // Arm the transfer, then show reads still see the shadow copy.
    task automatic t_arm();
        logic [15:0] v;
        wq[0] = 16'h0001;
        xfer(1'b0, DCSP_ARM_ADDR, 1, 1'b0);
        peek(7'h60, v);
        chk("active60", v, 16'h1234);
        peek(7'h5E, v);
        chk("active5e", v, 16'h5A0F);
        xfer(1'b1, DCSP_ARM_ADDR, 1, 1'b0);
        chk("armclear", rq[0], 16'h0000);
        wq[0] = 16'h0F0F;
        xfer(1'b0, DCSP_BURST_TOP, 1, 1'b0);
        xfer(1'b1, DCSP_BURST_TOP, 1, 1'b0);
        chk("shadow", rq[0], 16'h0F0F);
        peek(7'h60, v);
        chk("kept", v, 16'h1234);
    endtask

    // Both mode bits, three-line reads, and the way back.
    task automatic t_mode();
        wq[0] = 16'h4000;
        xfer(1'b0, DCSP_SETUP_ADDR, 1, 1'b0);
        chk("mode14", {15'h0000, three_line}, 16'h0001);
        xfer(1'b1, DCSP_BURST_TOP, 1, 1'b1);
        chk("rd3w", rq[0], 16'h0F0F);
        wq[0] = 16'h0002;
        xfer(1'b0, DCSP_SETUP_ADDR, 1, 1'b1);
        chk("mode1", {15'h0000, three_line}, 16'h0001);
        xfer(1'b1, 15'h005F, 1, 1'b1);
        chk("rd5f", rq[0], 16'hABCD);
        wq[0] = 16'h0000;
        xfer(1'b0, DCSP_SETUP_ADDR, 1, 1'b1);
        chk("mode0", {15'h0000, three_line}, 16'h0000);
    endtask

    // Writes past the register space are dropped.
    task automatic t_high();
        wq[0] = 16'hFFFF;
        xfer(1'b0, 15'h0061, 1, 1'b0);
        xfer(1'b1, 15'h0061, 1, 1'b0);
        chk("above", rq[0], 16'h0000);
    endtask

    // Reset for five cycles, then the scenarios in turn.
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_burst();
        t_arm();
        t_mode();
        t_high();
        wrap_up();
    end
endmodule // dac_config_serial_port_bench
`default_nettype wire
